// ### zmpc_pkg.sv
// Constants, codes and state type shared by the zone merge payload codec.
package zmpc_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] ZMPC_OFF_CTRL = 8'h00;
    localparam logic [7:0] ZMPC_OFF_STAT = 8'h04;
    localparam logic [7:0] ZMPC_OFF_FLAGS = 8'h08;
    localparam logic [7:0] ZMPC_OFF_ASLEN = 8'h0C;
    localparam logic [7:0] ZMPC_OFF_DBLEN = 8'h10;
    localparam logic [7:0] ZMPC_OFF_CLR = 8'h14;
    // Control register field positions and value after reset.
    localparam int ZMPC_CTRL_ENH = 0;
    localparam int ZMPC_CTRL_EN = 1;
    localparam logic [1:0] ZMPC_CTRL_RST = 2'h0;
    // Payload codes.
    localparam logic [7:0] ZMPC_CMD_MERGE = 8'h22;
    localparam logic [7:0] ZMPC_VER_BASIC = 8'h00;
    localparam logic [7:0] ZMPC_VER_ENH = 8'h01;
    localparam logic [7:0] ZMPC_ACC_CODE = 8'h02;
    localparam logic [7:0] ZMPC_RJT_CODE = 8'h01;
    // Reason code for unable to complete; value is a plain default.
    localparam logic [7:0] ZMPC_RSN_UNABLE = 8'h0A;
    // Explanation codes carried in the reject reply.
    localparam logic [7:0] ZMPC_EXP_CMD = 8'h01;
    localparam logic [7:0] ZMPC_EXP_VER = 8'h02;
    localparam logic [7:0] ZMPC_EXP_LEN = 8'h03;
    localparam logic [7:0] ZMPC_EXP_OBJ = 8'h04;
    localparam logic [7:0] ZMPC_EXP_MBR = 8'h05;
    localparam logic [7:0] ZMPC_EXP_DUP = 8'h06;
    // Object and member type codes; set and alias codes are plain defaults.
    localparam logic [7:0] ZMPC_OBJ_ZSET = 8'h01;
    localparam logic [7:0] ZMPC_OBJ_ZONE = 8'h02;
    localparam logic [7:0] ZMPC_OBJ_ALIAS = 8'h03;
    localparam logic [7:0] ZMPC_OBJ_ZREF = 8'h04;
    localparam logic [7:0] ZMPC_MBR_MIN = 8'h01;
    localparam logic [7:0] ZMPC_MBR_PID = 8'h03;
    localparam logic [7:0] ZMPC_MBR_ALIAS = 8'h04;
    // Enhanced flag bit positions.
    localparam int ZMPC_FLG_RESTRICT = 2;
    localparam int ZMPC_FLG_DENYDEF = 3;
    localparam int ZMPC_FLG_DBSUP = 4;
    localparam int ZMPC_FLG_DBEN = 5;
    // Last byte index of each counted field and of the reply.
    localparam logic [1:0] ZMPC_N_BLEN = 2'd1;
    localparam logic [1:0] ZMPC_N_ERSV = 2'd1;
    localparam logic [1:0] ZMPC_N_WORD = 2'd3;
    localparam logic [2:0] ZMPC_N_REPLY = 3'd7;
    // Parser states.
    typedef enum logic [3:0] {
        ZMPC_IDLE, ZMPC_VER, ZMPC_BLEN, ZMPC_ERSV, ZMPC_EFLG, ZMPC_ELEN,
        ZMPC_ASB, ZMPC_DLEN, ZMPC_DBB, ZMPC_DRAIN, ZMPC_REPLY
    } zmpc_state_t;
endpackage

// ### zmpc_codec.sv
// Zone merge request parser and accept or reject reply builder with APB registers.
`timescale 1ns/1ps
`default_nettype none
module zmpc_codec (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received request bytes.
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // Object and member type reports from the object walker.
    input wire logic chk_valid,
    input wire logic chk_member,
    input wire logic [7:0] chk_parent,
    input wire logic [7:0] chk_code,
    input wire logic chk_dup,
    // Reply bytes.
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_reject,
    input wire logic tx_ready,
    // Link isolation request.
    output logic isolate
);
    import zmpc_pkg::*;

    // Whole state of the block.
    typedef struct packed {
        zmpc_state_t st;
        logic [1:0] fcnt;
        logic [31:0] rem;
        logic enh;
        logic [31:0] flags;
        logic [31:0] as_len;
        logic [31:0] db_len;
        logic err;
        logic [7:0] expl;
        logic [2:0] tix;
        logic [7:0] txd;
        logic [1:0] ctrl;
        logic done;
        logic acc;
        logic iso;
        logic ack;
        logic [31:0] rdata;
    } zmpc_regs_t;

    zmpc_regs_t s_q;
    zmpc_regs_t s_d;

    // Returns one if an object or member type is legal in its place.
    function automatic logic zmpc_type_ok(input logic enh, input logic in_db, input logic mbr,
                                          input logic [7:0] par, input logic [7:0] code);
        logic ok;
        ok = 1'b0;
        if (!mbr) begin
            // Active sets carry only zones; an enhanced database takes all objects.
            ok = in_db ? (enh || code != ZMPC_OBJ_ZREF) : (code == ZMPC_OBJ_ZONE);
        end else if (par == ZMPC_OBJ_ZSET) begin
            ok = in_db && (code == (enh ? ZMPC_OBJ_ZREF : ZMPC_OBJ_ZONE));
        end else if (par == ZMPC_OBJ_ZONE) begin
            if (!in_db) begin
                ok = enh ? (code != ZMPC_MBR_ALIAS)
                         : (code >= ZMPC_MBR_MIN && code <= ZMPC_MBR_PID);
            end else begin
                ok = enh || (code >= ZMPC_MBR_MIN && code <= ZMPC_MBR_ALIAS);
            end
        end else if (par == ZMPC_OBJ_ALIAS) begin
            ok = in_db && (enh ? (code != ZMPC_MBR_ALIAS)
                               : (code >= ZMPC_MBR_MIN && code <= ZMPC_MBR_PID));
        end
        return ok;
    endfunction

    // Byte of the reply at a given index.
    function automatic logic [7:0] zmpc_reply(input logic rej, input logic [2:0] idx, input logic [7:0] ex);
        logic [7:0] b;
        b = 8'h00;
        if (idx == 3'd0) begin
            b = rej ? ZMPC_RJT_CODE : ZMPC_ACC_CODE;
        end else if (rej && idx == 3'd5) begin
            b = ZMPC_RSN_UNABLE;
        end else if (rej && idx == 3'd6) begin
            b = ex;
        end
        return b;
    endfunction

    logic rx_fire;
    logic tx_fire;
    logic [31:0] len_shift;
    logic apb_acc;
    logic [7:0] ex_new;
    logic ends;

    // Handshakes: bytes are taken only when enabled and no reply is pending.
    assign rx_ready = s_q.ctrl[ZMPC_CTRL_EN] && (s_q.st != ZMPC_REPLY);
    assign rx_fire = rx_valid && rx_ready;
    assign tx_valid = (s_q.st == ZMPC_REPLY);
    assign tx_fire = tx_valid && tx_ready;
    assign tx_data = s_q.txd;
    assign tx_last = tx_valid && (s_q.tix == ZMPC_N_REPLY);
    assign tx_reject = s_q.err;
    assign isolate = s_q.iso;
    assign len_shift = {s_q.rem[23:0], rx_data};
    assign apb_acc = psel && penable && s_q.ack;
    assign pready = s_q.ack;
    assign prdata = s_q.rdata;
    assign pslverr = s_q.ack && !(paddr <= ZMPC_OFF_CLR && paddr[1:0] == 2'b00);

    // Next-state logic for parser, reply and registers.
    always_comb begin
        s_d = s_q;
        ex_new = 8'h00;
        ends = 1'b0;
        // Parser: each accepted byte advances through the fields.
        if (rx_fire) begin
            unique case (s_q.st)
                ZMPC_IDLE: begin
                    s_d.err = 1'b0;
                    s_d.expl = 8'h00;
                    s_d.flags = 32'h0000_0000;
                    s_d.as_len = 32'h0000_0000;
                    s_d.db_len = 32'h0000_0000;
                    s_d.st = ZMPC_VER;
                    if (rx_data != ZMPC_CMD_MERGE) begin
                        ex_new = ZMPC_EXP_CMD;
                    end
                end
                ZMPC_VER: begin
                    s_d.enh = (rx_data == ZMPC_VER_ENH);
                    s_d.fcnt = 2'd0;
                    s_d.rem = 32'h0000_0000;
                    s_d.st = (rx_data == ZMPC_VER_ENH) ? ZMPC_ERSV : ZMPC_BLEN;
                    if (rx_data != ZMPC_VER_BASIC && rx_data != ZMPC_VER_ENH) begin
                        ex_new = ZMPC_EXP_VER;
                    end else if ((rx_data == ZMPC_VER_ENH) != s_q.ctrl[ZMPC_CTRL_ENH]) begin
                        ex_new = ZMPC_EXP_VER;
                    end
                end
                ZMPC_ERSV: begin
                    // Reserved bytes are skipped unread.
                    s_d.fcnt = s_q.fcnt + 2'd1;
                    if (s_q.fcnt == ZMPC_N_ERSV) begin
                        s_d.fcnt = 2'd0;
                        s_d.st = ZMPC_EFLG;
                    end
                end
                ZMPC_EFLG: begin
                    s_d.flags = {s_q.flags[23:0], rx_data};
                    s_d.fcnt = s_q.fcnt + 2'd1;
                    if (s_q.fcnt == ZMPC_N_WORD) begin
                        s_d.fcnt = 2'd0;
                        s_d.st = ZMPC_ELEN;
                    end
                end
                ZMPC_BLEN, ZMPC_ELEN: begin
                    // Basic length is two bytes of name plus list; enhanced is four of list only.
                    s_d.rem = len_shift;
                    s_d.fcnt = s_q.fcnt + 2'd1;
                    if (s_q.fcnt == ((s_q.st == ZMPC_BLEN) ? ZMPC_N_BLEN : ZMPC_N_WORD)) begin
                        s_d.as_len = len_shift;
                        s_d.fcnt = 2'd0;
                        s_d.st = (len_shift == 32'h0000_0000) ? ZMPC_DLEN : ZMPC_ASB;
                    end
                end
                ZMPC_ASB: begin
                    s_d.rem = s_q.rem - 32'd1;
                    if (s_q.rem == 32'd1) begin
                        s_d.rem = 32'h0000_0000;
                        s_d.st = ZMPC_DLEN;
                    end
                end
                ZMPC_DLEN: begin
                    s_d.rem = len_shift;
                    s_d.fcnt = s_q.fcnt + 2'd1;
                    if (s_q.fcnt == ZMPC_N_WORD) begin
                        s_d.db_len = len_shift;
                        s_d.fcnt = 2'd0;
                        s_d.st = ZMPC_DBB;
                        ends = (len_shift == 32'h0000_0000);
                    end
                end
                ZMPC_DBB: begin
                    s_d.rem = s_q.rem - 32'd1;
                    ends = (s_q.rem == 32'd1);
                    if (s_q.rem == 32'd0) begin
                        ex_new = ZMPC_EXP_LEN;
                    end
                end
                ZMPC_DRAIN: begin
                    s_d.st = ZMPC_DRAIN;
                end
                default: begin
                    s_d.st = s_q.st;
                end
            endcase
            // A frame that ends anywhere but on its last counted byte is malformed.
            if (rx_last && !ends && s_q.st != ZMPC_DRAIN && ex_new == 8'h00) begin
                ex_new = ZMPC_EXP_LEN;
            end
            if (ends && !rx_last && ex_new == 8'h00) begin
                ex_new = ZMPC_EXP_LEN;
            end
        end
        // Type reports from the walker are judged against the list in progress.
        if (chk_valid && (s_q.st == ZMPC_ASB || s_q.st == ZMPC_DBB) && ex_new == 8'h00) begin
            if (s_q.st == ZMPC_DBB && chk_dup) begin
                ex_new = ZMPC_EXP_DUP;
            end else if (!zmpc_type_ok(s_q.enh, s_q.st == ZMPC_DBB, chk_member, chk_parent, chk_code)) begin
                ex_new = chk_member ? ZMPC_EXP_MBR : ZMPC_EXP_OBJ;
            end
        end
        // The first error wins; later ones leave the explanation alone.
        if (ex_new != 8'h00 && !s_q.err) begin
            s_d.err = 1'b1;
            s_d.expl = ex_new;
            if (s_q.st != ZMPC_REPLY && !(rx_fire && rx_last)) begin
                s_d.st = ZMPC_DRAIN;
            end
        end
        // End of frame starts the reply.
        if (rx_fire && rx_last) begin
            s_d.st = ZMPC_REPLY;
            s_d.tix = 3'd0;
            s_d.txd = zmpc_reply(s_d.err, 3'd0, s_d.expl);
        end
        // Reply emission one byte per handshake.
        if (tx_fire) begin
            s_d.tix = s_q.tix + 3'd1;
            s_d.txd = zmpc_reply(s_q.err, s_q.tix + 3'd1, s_q.expl);
            if (s_q.tix == ZMPC_N_REPLY) begin
                s_d.st = ZMPC_IDLE;
                s_d.done = 1'b1;
                s_d.acc = !s_q.err;
            end
        end
        // APB: one wait state, then the access completes.
        s_d.ack = psel && penable && !s_q.ack;
        if (psel && penable && !s_q.ack && !pwrite) begin
            unique case (paddr)
                ZMPC_OFF_CTRL: s_d.rdata = {30'h0, s_q.ctrl};
                ZMPC_OFF_STAT: s_d.rdata = {8'h00, s_q.expl, 10'h000, s_q.enh, s_q.err, s_q.st != ZMPC_IDLE,
                                            s_q.iso, s_q.acc, s_q.done};
                ZMPC_OFF_FLAGS: s_d.rdata = {26'h0, s_q.flags[ZMPC_FLG_DBEN:ZMPC_FLG_RESTRICT], 2'b00};
                ZMPC_OFF_ASLEN: s_d.rdata = s_q.as_len;
                ZMPC_OFF_DBLEN: s_d.rdata = s_q.db_len;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (apb_acc && pwrite && paddr == ZMPC_OFF_CTRL) begin
            s_d.ctrl = pwdata[1:0];
        end
        // Software clears done and isolation; a new isolation in the same cycle wins.
        if (apb_acc && pwrite && paddr == ZMPC_OFF_CLR && pwdata[0]) begin
            s_d.done = 1'b0;
            s_d.iso = 1'b0;
        end
        // A reply that finishes under a clear still leaves done set and, for a reject, the link isolated.
        if (tx_fire && s_q.tix == ZMPC_N_REPLY) begin
            s_d.done = 1'b1;
            s_d.iso = s_q.err || s_d.iso;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: ZMPC_IDLE, ctrl: ZMPC_CTRL_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Checks on the protocol behaviour.
    a_cmd_reject: assert property (@(posedge core_clk) disable iff (!rstn)
        (rx_fire && s_q.st == ZMPC_IDLE && rx_data != ZMPC_CMD_MERGE) |=> s_q.err)
        else $error("bad command byte not flagged");
    a_ver_mismatch: assert property (@(posedge core_clk) disable iff (!rstn)
        (rx_fire && s_q.st == ZMPC_VER && !s_q.err && rx_data == ZMPC_VER_BASIC && s_q.ctrl[ZMPC_CTRL_ENH])
        |=> (s_q.err && s_q.expl == ZMPC_EXP_VER))
        else $error("version mismatch not flagged");
    a_acc_first: assert property (@(posedge core_clk) disable iff (!rstn)
        (tx_valid && s_q.tix == 3'd0 && !s_q.err) |-> tx_data == ZMPC_ACC_CODE)
        else $error("accept does not open with 02h");
    a_reply_len: assert property (@(posedge core_clk) disable iff (!rstn)
        (tx_fire && s_q.tix == 3'd0 && tx_ready) |-> !tx_last)
        else $error("reply too short");
    a_rjt_iso: assert property (@(posedge core_clk) disable iff (!rstn)
        (tx_fire && tx_last && tx_reject) |=> isolate)
        else $error("reject did not isolate");
    a_acc_noiso: assert property (@(posedge core_clk) disable iff (!rstn)
        (tx_fire && tx_last && !tx_reject && !isolate) |=> (!isolate && s_q.acc))
        else $error("accept isolated the link");
    a_rjt_expl: assert property (@(posedge core_clk) disable iff (!rstn)
        (tx_valid && s_q.tix == 3'd6 && tx_reject) |-> (tx_data == s_q.expl && tx_data != 8'h00))
        else $error("reject carries no explanation");
    a_basic_mbr: assert property (@(posedge core_clk) disable iff (!rstn)
        (chk_valid && s_q.st == ZMPC_ASB && !s_q.enh && !s_q.err && chk_member
         && chk_parent == ZMPC_OBJ_ZONE && chk_code == ZMPC_MBR_ALIAS) |=> s_q.err)
        else $error("alias member accepted in basic active set");
    a_enh_set: assert property (@(posedge core_clk) disable iff (!rstn)
        (chk_valid && s_q.st == ZMPC_DBB && s_q.enh && !s_q.err && chk_member && !chk_dup
         && chk_parent == ZMPC_OBJ_ZSET && chk_code == ZMPC_OBJ_ZREF) |=> !s_q.err)
        else $error("zone reference refused in enhanced set");
    a_db_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (rx_fire && rx_last && s_q.st == ZMPC_DLEN && s_q.fcnt == ZMPC_N_WORD && !s_q.err
         && len_shift == 32'h0000_0000) |=> !s_q.err)
        else $error("empty database refused");
endmodule // zmpc_codec
`default_nettype wire

// ### zmpc_peer.sv
// Far-side model: the adjacent switch controller that sends merge requests and takes replies.
`timescale 1ns/1ps
`default_nettype none
module zmpc_peer (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Request bytes sent to the codec.
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // Walker type report riding with one chosen byte.
    output logic chk_valid,
    output logic chk_member,
    output logic [7:0] chk_parent,
    output logic [7:0] chk_code,
    output logic chk_dup,
    // Reply bytes from the codec.
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_reject,
    output logic tx_ready
);
    // Request bytes, report slot and pacing, all loaded by the bench.
    logic [7:0] req[$];
    int cidx;
    logic [17:0] crep;
    logic slow;
    // Reply bytes taken, their count, the index marked last and the reject flag.
    logic [7:0] rsp[8];
    logic [31:0] rsp_n;
    logic [31:0] last_at;
    logic rej_seen;

    // Nothing is offered at start and the reply sink is ready.
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        chk_valid = 1'b0;
        {chk_member, chk_dup, chk_parent, chk_code} = 18'h0_0000;
        tx_ready = 1'b1;
        cidx = -1;
        crep = 18'h0_0000;
        slow = 1'b0;
        rsp_n = 32'h0000_0000;
        last_at = 32'h0000_0000;
        rej_seen = 1'b0;
    end

    // Takes reply bytes; a slow far side is ready only every other cycle.
    always @(posedge core_clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready && rsp_n < 32'h0000_0008) begin
            rsp[rsp_n[2:0]] <= tx_data;
            rsp_n <= rsp_n + 32'h0000_0001;
            // Last mark position is recorded for the bench.
            if (tx_last) begin
                last_at <= rsp_n;
            end
            if (rsp_n == 32'h0000_0000) begin
                rej_seen <= tx_reject;
            end
        end
    end

    // Offers each byte until taken; the final byte carries the last mark.
    task automatic send();
        int guard;
        for (int i = 0; i < req.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= req[i];
            rx_last <= (i == req.size() - 1);
            chk_valid <= (i == cidx);
            {chk_member, chk_dup, chk_parent, chk_code} <= crep;
            guard = 0;
            do begin
                @(posedge core_clk);
                guard++;
            end while (rx_ready !== 1'b1 && guard < 100);
            // A released data line shows the inverse, never the stale byte.
            if (slow || i == req.size() - 1) begin
                rx_valid <= 1'b0;
                rx_data <= ~req[i];
                rx_last <= 1'b0;
                chk_valid <= 1'b0;
                if (slow) begin
                    @(posedge core_clk);
                end
            end
        end
    endtask
endmodule // zmpc_peer
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the zone merge payload codec.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import zmpc_pkg::*;
    // One request case beside the reply it should draw.
    typedef struct {
        logic [1:0] ctrl;
        logic [7:0] cmd;
        logic [7:0] ver;
        logic enh;
        logic [31:0] flg;
        int alen;
        int dlen;
        int cut;
        int cidx;
        logic [17:0] crep;
        logic rej;
        logic [7:0] expl;
    } zmpc_row_t;
    // Clock, reset and bus master signals.
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    // Design outputs and stream wires.
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, rx_last, rx_ready, chk_valid, chk_member, chk_dup;
    logic [7:0] rx_data, chk_parent, chk_code, tx_data;
    logic tx_valid, tx_last, tx_reject, tx_ready, isolate;
    // Bookkeeping.
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int check_count = 0;
    zmpc_row_t rows[17];

    zmpc_codec zmpc_codec_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_valid, .rx_data, .rx_last, .rx_ready, .chk_valid, .chk_member, .chk_parent, .chk_code,
        .chk_dup, .tx_valid, .tx_data, .tx_last, .tx_reject, .tx_ready, .isolate);
    zmpc_peer zmpc_peer_inst (.core_clk, .rstn, .rx_valid, .rx_data, .rx_last, .rx_ready, .chk_valid,
        .chk_member, .chk_parent, .chk_code, .chk_dup, .tx_valid, .tx_data, .tx_last, .tx_reject, .tx_ready);

    // 100 MHz clock.
    always #5 core_clk = ~core_clk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic conclude();
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int guard;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        guard = 0;
        do begin
            @(posedge core_clk);
            guard++;
        end while (pready !== 1'b1 && guard < 50);
        if (guard >= 50) begin
            failures++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // Queues a field of n bytes, most significant first.
    task automatic put(input logic [31:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            zmpc_peer_inst.req.push_back(v[8*k +: 8]);
        end
    endtask

    // Sends one request, then checks the reply, isolation and status.
    task automatic run_row(input zmpc_row_t r);
        int guard;
        logic [7:0] eb;
        apb(1'b1, ZMPC_OFF_CTRL, {30'h0000_0000, r.ctrl});
        zmpc_peer_inst.req.delete();
        put({r.cmd, r.ver}, 2);
        if (r.enh) begin
            put(32'h0000_AA55, 2);
            put(r.flg, 4);
            put(r.alen, 4);
        end else begin
            put(r.alen, 2);
        end
        repeat (r.alen) put(32'h0000_005A, 1);
        put(r.dlen, 4);
        repeat (r.dlen) put(32'h0000_00C3, 1);
        repeat (r.cut) void'(zmpc_peer_inst.req.pop_back());
        zmpc_peer_inst.cidx = r.cidx;
        zmpc_peer_inst.crep = r.crep;
        zmpc_peer_inst.rsp_n = 32'h0000_0000;
        zmpc_peer_inst.send();
        guard = 0;
        while (zmpc_peer_inst.rsp_n !== 32'h0000_0008 && guard < 200) begin
            @(posedge core_clk);
            guard++;
        end
        if (guard >= 200) begin
            failures++;
        end
        for (int k = 0; k < 8; k++) begin
            eb = (k == 0) ? (r.rej ? ZMPC_RJT_CODE : ZMPC_ACC_CODE) : 8'h00;
            if (r.rej && k == 5) eb = ZMPC_RSN_UNABLE;
            if (r.rej && k == 6) eb = r.expl;
            check("reply byte", zmpc_peer_inst.rsp[k], eb);
        end
        check("last mark", zmpc_peer_inst.last_at, 32'h0000_0007);
        check("reject flag", zmpc_peer_inst.rej_seen, r.rej);
        check("isolate", isolate, r.rej);
        apb(1'b0, ZMPC_OFF_STAT, 32'h0000_0000);
        check("status", {29'h0000_0000, rdat[2:0]}, {29'h0000_0000, r.rej, !r.rej, 1'b1});
        if (r.rej) check("explanation", {24'h00_0000, rdat[23:16]}, {24'h00_0000, r.expl});
        if (r.enh && !r.rej) begin
            apb(1'b0, ZMPC_OFF_FLAGS, 32'h0000_0000);
            check("flags", rdat, r.flg & 32'h0000_003C);
            apb(1'b0, ZMPC_OFF_ASLEN, 32'h0000_0000);
            check("active length", rdat, r.alen);
        end
        apb(1'b1, ZMPC_OFF_CLR, 32'h0000_0001);
    endtask

    // Cuts a hang short.
    initial begin
        #500_000;
        failures++;
        conclude();
    end

    // Main sequence: reset, the case table, then the awkward cases.
    initial begin
        rows = '{
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 0, 0, 0, -1, 18'h0_0000, 1'b0, 8'h00},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, -1, 18'h0_0000, 1'b0, 8'h00},
            '{2'h2, 8'h23, 8'h00, 1'b0, 32'h0000_0000, 0, 0, 0, -1, 18'h0_0000, 1'b1, 8'h01},
            '{2'h2, 8'h22, 8'h02, 1'b0, 32'h0000_0000, 0, 0, 0, -1, 18'h0_0000, 1'b1, 8'h02},
            '{2'h2, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 0, 0, 0, -1, 18'h0_0000, 1'b1, 8'h02},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 1, -1, 18'h0_0000, 1'b1, 8'h03},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, 4, 18'h0_0003, 1'b1, 8'h04},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, 4, 18'h2_0204, 1'b1, 8'h05},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, 10, 18'h1_0002, 1'b1, 8'h06},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, 10, 18'h2_0304, 1'b1, 8'h05},
            '{2'h2, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 2, 1, 0, 10, 18'h2_0204, 1'b0, 8'h00},
            '{2'h3, 8'h22, 8'h01, 1'b1, 32'hFFFF_FFEB, 2, 1, 0, -1, 18'h0_0000, 1'b0, 8'h00},
            '{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0014, 2, 0, 0, 12, 18'h2_0205, 1'b0, 8'h00},
            '{2'h3, 8'h22, 8'h00, 1'b0, 32'h0000_0000, 0, 0, 0, -1, 18'h0_0000, 1'b1, 8'h02},
            '{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 0, 12, 18'h2_0204, 1'b1, 8'h05},
            '{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 0, 18, 18'h2_0102, 1'b1, 8'h05},
            '{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 0, 18, 18'h2_0304, 1'b1, 8'h05}
        };
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check("idle isolate", isolate, 1'b0);
        check("idle reply", tx_valid, 1'b0);
        foreach (rows[i]) run_row(rows[i]);
        // Database zone reference object and a short enhanced body.
        run_row('{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 0, 18, 18'h0_0004, 1'b0, 8'h00});
        run_row('{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 0, 18, 18'h2_0104, 1'b0, 8'h00});
        run_row('{2'h3, 8'h22, 8'h01, 1'b1, 32'h0000_0000, 2, 1, 1, -1, 18'h0_0000, 1'b1, 8'h03});
        // Slow far side: gaps between request bytes and a stalling reply sink.
        zmpc_peer_inst.slow = 1'b1;
        run_row(rows[11]);
        run_row(rows[4]);
        zmpc_peer_inst.slow = 1'b0;
        // Unmapped address is refused with an error and reads zero.
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("unmapped error", rerr, 1'b1);
        check("unmapped data", rdat, 32'h0000_0000);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
